// ---- design/hs_cc_pkg.sv ----
`default_nettype none
package hs_cc_pkg;
  // bus geometry, byte addresses
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam logic [ADDR_W-1:0] REG_CTRL = 6'h00;
  localparam logic [ADDR_W-1:0] REG_CMP = 6'h04;
  localparam logic [ADDR_W-1:0] REG_ZONE_LO = 6'h08;
  localparam logic [ADDR_W-1:0] REG_ZONE_HI = 6'h0C;
  localparam logic [ADDR_W-1:0] REG_PIN_CTRL = 6'h10;
  localparam logic [ADDR_W-1:0] REG_RESULT = 6'h14;
  localparam logic [ADDR_W-1:0] REG_STATUS = 6'h18;
  localparam logic [ADDR_W-1:0] REG_MASK = 6'h1C;
  localparam logic [ADDR_W-1:0] REG_COUNT_A = 6'h20;
  localparam logic [ADDR_W-1:0] REG_COUNT_B = 6'h24;
  localparam logic [ADDR_W-1:0] REG_CAPTURE_A_LOW = 6'h28;
  localparam logic [ADDR_W-1:0] REG_CAPTURE_A_HIGH = 6'h2C;
  localparam logic [ADDR_W-1:0] REG_CAPTURE_B_LOW = 6'h30;
  localparam logic [ADDR_W-1:0] REG_CAPTURE_B_HIGH = 6'h34;
  // widths
  localparam int CNT_W = 32;
  localparam int HALF_W = 16;
  localparam int NUM_PINS = 4;
  localparam int NUM_OUT = 4;
  localparam int ZONE_W = 3;
  localparam int CTRL_W = 10;
  localparam int PIN_CTRL_W = 12;
  localparam int RESULT_W = 12;
  localparam int STATUS_W = 4;
  // register field positions
  localparam int CTRL_EN = 0;
  localparam int CTRL_OP_LSB = 1;
  localparam int CTRL_HW = 3;
  localparam int CTRL_CNT = 4;
  localparam int CTRL_DEST_LSB = 5;
  localparam int CTRL_IDX_LSB = 7;
  localparam int CTRL_ISR = 9;
  localparam int PIN_IRQ_LSB = 0;
  localparam int PIN_FALL_LSB = 4;
  localparam int PIN_RST_LSB = 8;
  localparam int RES_FAST_LSB = 0;
  localparam int RES_SLOW_LSB = 4;
  localparam int RES_RELAY = 8;
  localparam int RES_ZONE_LSB = 9;
  localparam int ST_MATCH = 0;
  localparam int ST_CAP_A = 1;
  localparam int ST_CAP_B = 2;
  localparam int ST_RESET = 3;
  // reset pins 1,3,4,5 in index order; a set bit routes to counter b
  localparam logic [NUM_PINS-1:0] PIN_TO_B = 4'hA;
  // scan period
  localparam int CLK_MHZ = 100;
  localparam int SCAN_TIME_US = 10;
  localparam int SCAN_CYCLES = SCAN_TIME_US * CLK_MHZ;
  typedef enum logic [1:0] {
    OP_SET = 2'h0,
    OP_RESET = 2'h1,
    OP_ZONE = 2'h2
  } op_t;
  typedef enum logic [1:0] {
    DEST_FAST = 2'h0,
    DEST_SLOW = 2'h1,
    DEST_RELAY = 2'h2,
    DEST_CNT = 2'h3
  } dest_t;
endpackage
`default_nettype wire

// ---- design/cnt_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface cnt_if #(parameter int W = 32);
  logic [W-1:0] count;
  logic [W-1:0] prev;
  logic step;
  logic up;
  logic clear;
  modport counter (output count, output prev, output step, output up,
    input clear);
  modport user (input count, input prev, input step, input up,
    output clear);
endinterface
`default_nettype wire

// ---- design/pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta;

  // two stages, only the second is read outside
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta <= '0;
      o_q <= '0;
    end else begin
      meta <= i_d;
      o_q <= meta;
    end
  end
endmodule
`default_nettype wire

// ---- design/pulse_counter.sv ----
`timescale 1ns/1ps
`default_nettype none
module pulse_counter #(
  parameter int W = 32
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_pulse,
  input wire logic i_up,
  cnt_if.counter port
);
  logic last;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      last <= 1'b0;
    end else begin
      last <= i_pulse;
    end
  end

  // clear wins over a coinciding pulse so a captured value is exact
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      port.count <= '0;
      port.prev <= '0;
      port.step <= 1'b0;
      port.up <= 1'b0;
    end else if (port.clear) begin
      port.count <= '0;
      port.step <= 1'b0;
    end else if (i_pulse && !last) begin
      port.prev <= port.count;
      port.count <= i_up ? port.count + W'(1) : port.count - W'(1);
      port.step <= 1'b1;
      port.up <= i_up;
    end else begin
      port.step <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- design/hs_counter_compare_capture.sv ----
`timescale 1ns/1ps
`default_nettype none
module hs_counter_compare_capture
  import hs_cc_pkg::*;
#(
  parameter int SCAN_CYC = SCAN_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [ADDR_W-1:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [BE_W-1:0] i_byteenable,
  input wire logic [DATA_W-1:0] i_writedata,
  output logic [DATA_W-1:0] o_readdata,
  output logic o_waitrequest,
  input wire logic i_pulse_a,
  input wire logic i_pulse_b,
  input wire logic i_dir_a,
  input wire logic i_dir_b,
  input wire logic [NUM_PINS-1:0] i_reset_pin,
  output logic [NUM_OUT-1:0] o_fast_outputs,
  output logic [NUM_OUT-1:0] o_slow_outputs,
  output logic o_result_relay,
  output logic [ZONE_W-1:0] o_zone,
  output logic o_isr_req,
  output logic o_irq
);
  localparam int SCAN_CW = $clog2(SCAN_CYC + 1);

  function automatic logic [DATA_W-1:0] merge(
    input logic [DATA_W-1:0] old, input logic [DATA_W-1:0] nw,
    input logic [BE_W-1:0] be);
    logic [DATA_W-1:0] r;
    r = old;
    for (int i = 0; i < BE_W; i++) begin
      if (be[i]) begin
        r[8*i+:8] = nw[8*i+:8];
      end
    end
    return r;
  endfunction

  logic [7:0] sync_q;
  logic ack;
  logic wr_go;
  logic [CTRL_W-1:0] ctrl;
  logic [CNT_W-1:0] cmp_val;
  logic [CNT_W-1:0] zone_lo;
  logic [CNT_W-1:0] zone_hi;
  logic [PIN_CTRL_W-1:0] pin_ctrl;
  logic [STATUS_W-1:0] status;
  logic [STATUS_W-1:0] mask;
  logic [STATUS_W-1:0] events;
  logic [CNT_W-1:0] cap_a;
  logic [CNT_W-1:0] cap_b;
  logic [NUM_OUT-1:0] slow_img;
  logic [DATA_W-1:0] rd_mux;
  logic [DATA_W-1:0] result_word;
  logic [DATA_W-1:0] result_new;
  logic [SCAN_CW-1:0] scan_cnt;
  logic scan_tick;
  logic [NUM_PINS-1:0] pin_prev;
  logic [NUM_PINS-1:0] pin_now;
  logic [NUM_PINS-1:0] pin_edge;
  logic [NUM_PINS-1:0] irq_ev;
  logic [NUM_PINS-1:0] rst_ev;
  logic cap_a_ev;
  logic cap_b_ev;
  cnt_if #(.W(CNT_W)) ca ();
  cnt_if #(.W(CNT_W)) cb ();

  // every pin passes two flops before any decision is made
  pin_sync #(.W(8)) u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_d({i_reset_pin, i_dir_b, i_dir_a, i_pulse_b, i_pulse_a}),
    .o_q(sync_q)
  );

  pulse_counter #(.W(CNT_W)) u_cnt_a (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_pulse(sync_q[0]),
    .i_up(sync_q[2]),
    .port(ca.counter)
  );

  pulse_counter #(.W(CNT_W)) u_cnt_b (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_pulse(sync_q[1]),
    .i_up(sync_q[3]),
    .port(cb.counter)
  );

  // control field decode
  wire en = ctrl[CTRL_EN];
  wire op_t op = op_t'(ctrl[CTRL_OP_LSB+:2]);
  wire hw = ctrl[CTRL_HW];
  wire cnt_sel = ctrl[CTRL_CNT];
  wire dest_t dest = dest_t'(ctrl[CTRL_DEST_LSB+:2]);
  wire [1:0] idx = ctrl[CTRL_IDX_LSB+:2];
  wire isr_en = ctrl[CTRL_ISR];

  // selected counter view
  wire sel_step = cnt_sel ? cb.step : ca.step;
  wire sel_up = cnt_sel ? cb.up : ca.up;
  wire [CNT_W-1:0] sel_count = cnt_sel ? cb.count : ca.count;
  wire [CNT_W-1:0] sel_prev = cnt_sel ? cb.prev : ca.prev;

  // software compare looks at the new value, hardware at the old one
  wire sw_hit = sel_step && sel_count == cmp_val;
  wire hw_hit = sel_step && sel_prev == cmp_val &&
    (op == OP_SET ? sel_up : !sel_up);
  wire fire = en && op != OP_ZONE && (hw ? hw_hit : sw_hit);
  wire set_fire = fire && op == OP_SET;
  wire clr_fire = fire && op == OP_RESET;
  wire zone_fire = en && op == OP_ZONE && sel_step;
  wire cnt_clr = clr_fire && dest == DEST_CNT;

  // avalon slave: one wait state, answer on the second edge
  assign o_waitrequest = (i_read | i_write) & ~ack;
  assign wr_go = i_write & ack;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ack <= 1'b0;
    end else begin
      ack <= (i_read | i_write) & ~ack;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_readdata <= '0;
    end else if (i_read && !ack) begin
      o_readdata <= rd_mux;
    end
  end

  // unmapped addresses read zero
  always_comb begin
    rd_mux = '0;
    case (i_address)
      REG_CTRL: rd_mux = DATA_W'(ctrl);
      REG_CMP: rd_mux = cmp_val;
      REG_ZONE_LO: rd_mux = zone_lo;
      REG_ZONE_HI: rd_mux = zone_hi;
      REG_PIN_CTRL: rd_mux = DATA_W'(pin_ctrl);
      REG_RESULT: rd_mux = result_word;
      REG_STATUS: rd_mux = DATA_W'(status);
      REG_MASK: rd_mux = DATA_W'(mask);
      REG_COUNT_A: rd_mux = ca.count;
      REG_COUNT_B: rd_mux = cb.count;
      REG_CAPTURE_A_LOW: rd_mux = DATA_W'(cap_a[HALF_W-1:0]);
      REG_CAPTURE_A_HIGH: rd_mux = DATA_W'(cap_a[CNT_W-1:HALF_W]);
      REG_CAPTURE_B_LOW: rd_mux = DATA_W'(cap_b[HALF_W-1:0]);
      REG_CAPTURE_B_HIGH: rd_mux = DATA_W'(cap_b[CNT_W-1:HALF_W]);
      default: rd_mux = '0;
    endcase
  end

  // plain configuration registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl <= '0;
      cmp_val <= '0;
      zone_lo <= '0;
      zone_hi <= '0;
      pin_ctrl <= '0;
      mask <= '0;
    end else if (wr_go) begin
      case (i_address)
        REG_CTRL:
          ctrl <= CTRL_W'(merge(DATA_W'(ctrl), i_writedata, i_byteenable));
        REG_CMP: cmp_val <= merge(cmp_val, i_writedata, i_byteenable);
        REG_ZONE_LO: zone_lo <= merge(zone_lo, i_writedata, i_byteenable);
        REG_ZONE_HI: zone_hi <= merge(zone_hi, i_writedata, i_byteenable);
        REG_PIN_CTRL: pin_ctrl <= PIN_CTRL_W'(merge(DATA_W'(pin_ctrl),
          i_writedata, i_byteenable));
        REG_MASK:
          mask <= STATUS_W'(merge(DATA_W'(mask), i_writedata, i_byteenable));
        default: ;
      endcase
    end
  end

  // result points; a match overrides a software write in the same cycle
  assign result_word = DATA_W'({o_zone, o_result_relay, slow_img,
    o_fast_outputs});
  assign result_new = merge(result_word, i_writedata, i_byteenable);
  wire wr_result = wr_go && i_address == REG_RESULT;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_fast_outputs <= '0;
      slow_img <= '0;
      o_result_relay <= 1'b0;
    end else begin
      if (wr_result) begin
        o_fast_outputs <= result_new[RES_FAST_LSB+:NUM_OUT];
        slow_img <= result_new[RES_SLOW_LSB+:NUM_OUT];
        o_result_relay <= result_new[RES_RELAY];
      end
      // nothing but a write or a set match turns a cleared point on
      if (fire && dest == DEST_FAST) begin
        o_fast_outputs[idx] <= set_fire;
      end
      if (fire && dest == DEST_SLOW) begin
        slow_img[idx] <= set_fire;
      end
      if (fire && dest == DEST_RELAY) begin
        o_result_relay <= set_fire;
      end
    end
  end

  // zone result: below, inside, above on three consecutive points
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_zone <= '0;
    end else if (zone_fire) begin
      o_zone <= {sel_count > zone_hi,
        sel_count >= zone_lo && sel_count <= zone_hi,
        sel_count < zone_lo};
    end else if (wr_result) begin
      o_zone <= result_new[RES_ZONE_LSB+:ZONE_W];
    end
  end

  // scan divider; slow pins lag the image by up to one scan
  assign scan_tick = scan_cnt == SCAN_CW'(SCAN_CYC - 1);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      scan_cnt <= '0;
    end else begin
      scan_cnt <= scan_tick ? '0 : scan_cnt + SCAN_CW'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_slow_outputs <= '0;
    end else if (scan_tick) begin
      o_slow_outputs <= slow_img;
    end
  end

  // service request only for software compares, no scan wait
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_isr_req <= 1'b0;
    end else begin
      o_isr_req <= fire && !hw && isr_en;
    end
  end

  // reset pins: interrupt use takes the pin from plain reset
  assign pin_now = sync_q[7:4];
  assign pin_edge = (pin_ctrl[PIN_FALL_LSB+:NUM_PINS] & pin_prev & ~pin_now)
    | (~pin_ctrl[PIN_FALL_LSB+:NUM_PINS] & ~pin_prev & pin_now);
  assign irq_ev = pin_edge & pin_ctrl[PIN_IRQ_LSB+:NUM_PINS];
  assign rst_ev = pin_edge & ~pin_ctrl[PIN_IRQ_LSB+:NUM_PINS]
    & pin_ctrl[PIN_RST_LSB+:NUM_PINS];
  assign cap_a_ev = |(irq_ev & ~PIN_TO_B);
  assign cap_b_ev = |(irq_ev & PIN_TO_B);
  assign ca.clear = cap_a_ev || |(rst_ev & ~PIN_TO_B) ||
    (cnt_clr && !cnt_sel);
  assign cb.clear = cap_b_ev || |(rst_ev & PIN_TO_B) ||
    (cnt_clr && cnt_sel);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pin_prev <= '0;
    end else begin
      pin_prev <= pin_now;
    end
  end

  // capture takes the pre-clear value at the clearing edge
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cap_a <= '0;
      cap_b <= '0;
    end else begin
      if (cap_a_ev) begin
        cap_a <= ca.count;
      end
      if (cap_b_ev) begin
        cap_b <= cb.count;
      end
    end
  end

  // sticky status, write one to clear, a new event wins
  assign events = {|rst_ev, cap_b_ev, cap_a_ev, fire};

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      status <= '0;
    end else if (wr_go && i_address == REG_STATUS) begin
      status <= (status & ~i_writedata[STATUS_W-1:0]) | events;
    end else begin
      status <= status | events;
    end
  end

  assign o_irq = |(status & mask);

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_clr_relay;
    en && op == OP_RESET && !hw && dest == DEST_RELAY && sw_hit;
  endsequence
  sequence s_bus_req;
    (i_read || i_write) && !ack ##1 (i_read || i_write);
  endsequence

  AST_RESET_CLEARS_RELAY: assert property (
    s_clr_relay |=> !o_result_relay)
    else $error("relay not cleared on equal count");
  AST_RELAY_STAYS_OFF: assert property (
    !o_result_relay && !wr_result && !(set_fire && dest == DEST_RELAY)
    |=> !o_result_relay)
    else $error("cleared relay came back on");
  AST_FAST_AT_MATCH: assert property (
    clr_fire && dest == DEST_FAST |=> !o_fast_outputs[$past(idx)])
    else $error("fast output not cleared at match");
  AST_SLOW_AT_SCAN: assert property (
    !$stable(o_slow_outputs) |-> $past(scan_tick))
    else $error("slow output moved off scan end");
  AST_HW_UP_SET: assert property (
    en && hw && op == OP_SET && dest == DEST_RELAY && sel_step && sel_up
    && sel_prev == cmp_val |=> o_result_relay)
    else $error("hardware set missed upward step");
  AST_HW_DOWN_CLR: assert property (
    en && hw && op == OP_RESET && dest == DEST_RELAY && sel_step
    && !sel_up && sel_prev == cmp_val |=> !o_result_relay)
    else $error("hardware reset missed downward step");
  AST_ISR_NOW: assert property (
    en && !hw && isr_en && op != OP_ZONE && sw_hit
    |=> o_isr_req ##1 !o_isr_req)
    else $error("service request not one immediate pulse");
  AST_CAPTURE_A: assert property (
    cap_a_ev |=> cap_a == $past(ca.count) && ca.count == '0)
    else $error("capture a or clear wrong");
  AST_PRIORITY: assert property (
    |(pin_edge & pin_ctrl[PIN_IRQ_LSB+:NUM_PINS] & PIN_TO_B)
    |=> cap_b == $past(cb.count))
    else $error("enabled interrupt did not capture");
  AST_ZONE_ONEHOT: assert property (
    zone_fire |=> $onehot(o_zone))
    else $error("zone result not one-hot");
  AST_BUS_ANSWER: assert property (
    s_bus_req |-> !o_waitrequest)
    else $error("no answer after one wait state");
endmodule
`default_nettype wire

// ---- dv/pulse_src.sv ----
`timescale 1ns/1ps
`default_nettype none
module pulse_src #(
  parameter int HOLD = 4
) (
  input wire logic i_clk,
  output logic o_pulse_a,
  output logic o_pulse_b,
  output logic o_dir_a,
  output logic o_dir_b,
  output logic [3:0] o_reset_pin
);
  // pulse and reset lines idle low, direction lines idle high; each level held HOLD cycles for the synchronisers
  initial begin
    o_pulse_a = 1'b0;
    o_pulse_b = 1'b0;
    o_dir_a = 1'b1;
    o_dir_b = 1'b1;
    o_reset_pin = 4'h0;
  end
  // direction settles before the first edge, so no step is misread
  task automatic pulse(input logic ch, input logic up, input int n);
    @(posedge i_clk);
    if (ch) o_dir_b <= up;
    else o_dir_a <= up;
    repeat (HOLD) @(posedge i_clk);
    for (int i = 0; i < n; i++) begin
      if (ch) o_pulse_b <= 1'b1;
      else o_pulse_a <= 1'b1;
      repeat (HOLD) @(posedge i_clk);
      if (ch) o_pulse_b <= 1'b0;
      else o_pulse_a <= 1'b0;
      repeat (HOLD) @(posedge i_clk);
    end
  endtask
  // push-pull reset pin level
  task automatic pin(input int p, input logic lvl);
    @(posedge i_clk);
    o_reset_pin[p] <= lvl;
    repeat (HOLD) @(posedge i_clk);
  endtask
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import hs_cc_pkg::*;
;
  localparam int SCAN = 40;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [ADDR_W-1:0] i_address = 6'h00;
  logic i_read = 1'b0;
  logic i_write = 1'b0;
  logic [BE_W-1:0] i_byteenable = 4'hF;
  logic [DATA_W-1:0] i_writedata = 32'h0;
  logic [DATA_W-1:0] o_readdata;
  logic o_waitrequest, pa, pb, da, db, o_result_relay, o_isr_req, o_irq;
  logic [NUM_PINS-1:0] rpin;
  logic [NUM_OUT-1:0] o_fast_outputs, o_slow_outputs;
  logic [ZONE_W-1:0] o_zone;
  logic [31:0] ca = 32'h0, cb = 32'h0, q, c, lo, cap_a;
  int n_fail = 0, n_tests = 0, cyc = 0, isr_n = 0, seed = 17617, k, t0;
  logic ch;

  always #5 i_clk = ~i_clk;
  // cycle count for the hang limit; isr cycles sampled mid-cycle
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_of_test();
    end
  end
  always @(negedge i_clk) if (o_isr_req === 1'b1) isr_n++;

  hs_counter_compare_capture #(.SCAN_CYC(SCAN)) dut_u (.i_clk(i_clk),
    .i_rst(i_rst), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_byteenable(i_byteenable),
    .i_writedata(i_writedata), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .i_pulse_a(pa), .i_pulse_b(pb),
    .i_dir_a(da), .i_dir_b(db), .i_reset_pin(rpin),
    .o_fast_outputs(o_fast_outputs), .o_slow_outputs(o_slow_outputs),
    .o_result_relay(o_result_relay), .o_zone(o_zone),
    .o_isr_req(o_isr_req), .o_irq(o_irq));
  pulse_src src_u (.i_clk(i_clk), .o_pulse_a(pa), .o_pulse_b(pb),
    .o_dir_a(da), .o_dir_b(db), .o_reset_pin(rpin));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e,
      input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  // one access; request held until waitrequest seen low at an edge
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a,
      input logic [31:0] d);
    @(posedge i_clk);
    i_address <= a;
    i_writedata <= d;
    i_write <= w;
    i_read <= !w;
    // waitrequest and read data taken as they stand at the edge
    @(posedge i_clk);
    while (o_waitrequest !== 1'b0) @(posedge i_clk);
    q = o_readdata;
    i_write <= 1'b0;
    i_read <= 1'b0;
    // let the landing edge settle before outputs are looked at
    @(negedge i_clk);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input string s, input logic [ADDR_W-1:0] a,
      input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(s, e, q);
  endtask
  // pulses via the partner; the bench keeps its own count
  task automatic step(input logic h, input logic up, input int n);
    src_u.pulse(h, up, n);
    if (h) cb = up ? cb + n : cb - n;
    else ca = up ? ca + n : ca - n;
  endtask
  function automatic logic [31:0] ctrl_w(op_t op, logic hw, logic cs,
      dest_t d, logic [1:0] ix, logic isr);
    return {22'h0, isr, ix, d, cs, hw, op, 1'b1};
  endfunction
  function automatic logic [2:0] zone_exp(logic [31:0] v, l, h);
    return v < l ? 3'h1 : (v > h ? 3'h4 : 3'h2);
  endfunction
  function automatic logic obs(dest_t d, logic [1:0] ix);
    return d == DEST_FAST ? o_fast_outputs[ix] : o_result_relay;
  endfunction
  // approach the compare value, land on it, then pass it
  task automatic cmp_case(input op_t op, input logic hw, input logic up,
      input logic r0, input dest_t d);
    logic [1:0] ix;
    int n;
    ix = 2'($random(seed));
    n = 2 + $unsigned($random(seed)) % 4;
    wr(REG_CMP, up ? ca + n : ca - n);
    wr(REG_RESULT, r0 ? 32'h10F : 32'h0);
    wr(REG_CTRL, ctrl_w(op, hw, 1'b0, d, ix, 1'b0));
    step(1'b0, up, n - 1);
    chk("result before match", r0, obs(d, ix));
    step(1'b0, up, 1);
    chk("result at match", hw ? r0 : !r0, obs(d, ix));
    step(1'b0, up, 1);
    chk("result past match", !r0, obs(d, ix));
    $display("test compare op %0d hw %0d done", op, hw);
  endtask

  initial begin
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    // reset values, unmapped and read-only places
    wr(6'h38, 32'hFFFF_FFFF);
    wr(REG_COUNT_A, 32'h55);
    rd("ctrl reset", REG_CTRL, 32'h0);
    rd("status reset", REG_STATUS, 32'h0);
    rd("unmapped", 6'h38, 32'h0);
    // one byte lane only; the other lanes keep their reset zero
    @(posedge i_clk);
    i_byteenable <= 4'h2;
    wr(REG_ZONE_LO, 32'hA5A5_A5A5);
    @(posedge i_clk);
    i_byteenable <= 4'hF;
    rd("byte lane", REG_ZONE_LO, 32'h0000_A500);
    step(1'b0, 1'b1, 10);
    rd("count a", REG_COUNT_A, ca);
    step(1'b1, 1'b0, 20);
    rd("count b wrapped", REG_COUNT_B, cb);
    $display("test counting done");
    cmp_case(OP_SET, 1'b0, 1'b1, 1'b0, DEST_RELAY);
    cmp_case(OP_RESET, 1'b0, 1'b0, 1'b1, DEST_RELAY);
    cmp_case(OP_SET, 1'b1, 1'b1, 1'b0, DEST_FAST);
    cmp_case(OP_RESET, 1'b1, 1'b0, 1'b1, DEST_FAST);
    cmp_case(OP_RESET, 1'b0, 1'b1, 1'b1, DEST_FAST);
    // slow output waits for the scan tick after the match
    wr(REG_CMP, ca + 1);
    wr(REG_CTRL, ctrl_w(OP_RESET, 1'b0, 1'b0, DEST_SLOW, 2'h2, 1'b0));
    wr(REG_RESULT, 32'h0F0);
    k = 0;
    while (o_slow_outputs !== 4'hF && k < 100) begin
      @(negedge i_clk);
      k++;
    end
    t0 = cyc;
    step(1'b0, 1'b1, 1);
    chk("slow before tick", 4'hF, o_slow_outputs);
    rd("slow image", REG_RESULT, 32'h0B0);
    while (cyc < t0 + SCAN - 2) @(negedge i_clk);
    chk("slow just before tick", 4'hF, o_slow_outputs);
    while (cyc < t0 + SCAN + 2) @(negedge i_clk);
    chk("slow after tick", 4'hB, o_slow_outputs);
    $display("test slow output done");
    // service request, status, mask and clear
    wr(REG_STATUS, 32'hF);
    wr(REG_MASK, 32'h1);
    wr(REG_CMP, ca + 1);
    wr(REG_CTRL, ctrl_w(OP_SET, 1'b0, 1'b0, DEST_RELAY, 2'h0, 1'b1));
    k = isr_n;
    step(1'b0, 1'b1, 1);
    chk("isr pulse cycles", k + 1, isr_n);
    chk("irq raised", 1, o_irq);
    rd("match status", REG_STATUS, 32'h1);
    wr(REG_MASK, 32'h0);
    chk("irq masked", 0, o_irq);
    wr(REG_MASK, 32'h1);
    wr(REG_STATUS, 32'h1);
    chk("irq cleared", 0, o_irq);
    rd("status cleared", REG_STATUS, 32'h0);
    $display("test interrupt done");
    // counter b as the target of a reset compare, so select b is used
    wr(REG_CMP, cb + 2);
    wr(REG_CTRL, ctrl_w(OP_RESET, 1'b0, 1'b1, DEST_CNT, 2'h0, 1'b0));
    step(1'b1, 1'b1, 2);
    cb = 32'h0;
    rd("count b cleared", REG_COUNT_B, cb);
    step(1'b1, 1'b1, 1);
    rd("count b after clear", REG_COUNT_B, cb);
    rd("count a untouched", REG_COUNT_A, ca);
    $display("test counter target done");
    // zone below, inside and above
    lo = ca + 2;
    wr(REG_ZONE_LO, lo);
    wr(REG_ZONE_HI, lo + 1);
    wr(REG_CTRL, ctrl_w(OP_ZONE, 1'b0, 1'b0, DEST_RELAY, 2'h0, 1'b0));
    for (int i = 0; i < 5; i++) begin
      step(1'b0, 1'b1, 1);
      chk("zone", zone_exp(ca, lo, lo + 1), o_zone);
    end
    $display("test zone done");
    // capture per pin; plain reset also enabled but must lose
    wr(REG_CTRL, 32'h0);
    for (int p = 0; p < NUM_PINS; p++) begin
      ch = PIN_TO_B[p];
      step(ch, 1'b1, 1 + $unsigned($random(seed)) % 6);
      c = ch ? cb : ca;
      wr(REG_STATUS, 32'hF);
      wr(REG_PIN_CTRL, 32'h101 << p);
      src_u.pin(p, 1'b1);
      repeat (4) @(posedge i_clk);
      rd("capture low", ch ? REG_CAPTURE_B_LOW : REG_CAPTURE_A_LOW,
        {16'h0, c[15:0]});
      rd("capture high", ch ? REG_CAPTURE_B_HIGH : REG_CAPTURE_A_HIGH,
        {16'h0, c[31:16]});
      rd("count cleared", ch ? REG_COUNT_B : REG_COUNT_A, 0);
      rd("capture status", REG_STATUS, ch ? 4 : 2);
      if (ch) cb = 32'h0;
      else begin
        ca = 32'h0;
        cap_a = c;
      end
      src_u.pin(p, 1'b0);
    end
    // plain reset on the falling edge, interrupt off
    step(1'b0, 1'b1, 3);
    wr(REG_STATUS, 32'hF);
    wr(REG_PIN_CTRL, 32'h110);
    src_u.pin(0, 1'b1);
    rd("count kept on rise", REG_COUNT_A, ca);
    src_u.pin(0, 1'b0);
    repeat (4) @(posedge i_clk);
    rd("count reset on fall", REG_COUNT_A, 0);
    rd("reset status", REG_STATUS, 32'h8);
    rd("capture kept", REG_CAPTURE_A_LOW, {16'h0, cap_a[15:0]});
    $display("test capture done");
    end_of_test();
  end
endmodule
`default_nettype wire
